// ===== core/sdc_decoder.sv
// module: synchronous dram command pin decoder with bank state and data lanes
`timescale 1ns/10ps
// Overview of operation
// [R01] chip select high masks every command for that cycle
// [R02] strobes and write enable are registered on rising edge, decoded together
// [R03] row strobe low, column strobe high: write enable picks activate/precharge
// [R04] activate moves the selected bank to the active state
// [R05] precharge returns the selected bank to idle
// [R06] column strobe low, row strobe high: write enable picks read or write
// [R07] byte masks gate read drivers and block write storage per lane
// [R08] all sixteen data lines move on rising edges, masked per lane
// [R09] activate applies only to idle bank and latches row address
// [R10] precharge-all idles every bank, accepted in any bank state
// [R11] controller deselects or sends no-operation when idle
module sdc_decoder
  import sdc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              chipSelN,
  input  wire logic              rowStrobeN,
  input  wire logic              colStrobeN,
  input  wire logic              writeEnN,
  input  wire logic [BANK_W-1:0] bankSel,
  input  wire logic [ROW_W-1:0]  addr,
  input  wire logic              lower_byte_mask,
  input  wire logic              upper_byte_mask,
  input  wire logic [DATA_W-1:0] data_lines_in,
  input  wire logic [DATA_W-1:0] readData,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic      [DATA_W-1:0] data_lines_oe,
  output logic      [DATA_W-1:0] writeData,
  output logic      [1:0]        writeLaneEn,
  output logic      [BANK_N-1:0] bankActive,
  output logic      [ROW_W-1:0]  openRow,
  output logic      [BANK_W-1:0] accessBank,
  output logic      [COL_W-1:0]  accessCol,
  output logic                   readStrobe,
  output logic                   writeStrobe,
  output logic                   row_open_command,
  output logic                   all_bank_close_command
);
  typedef struct packed {
    logic              csN1, rasN1, casN1, weN1;
    logic              csN,  rasN,  casN,  weN;
    logic [BANK_W-1:0] ba1, ba;
    logic [ROW_W-1:0]  ad1, ad;
    logic [1:0]        dqm1, dqm;
    logic [DATA_W-1:0] dq1, dq;
    logic [BANK_N-1:0] active;
    logic [ROW_W-1:0]  row;
    logic [BANK_W-1:0] aBank;
    logic [COL_W-1:0]  aCol;
    logic              rd, wr, act, pall;
    logic [DATA_W-1:0] dout;
  } sdc_state_t;

  sdc_state_t st;
  sdc_state_t next_st;
  sdc_cmd_t   cmd;

  sdc_lane_if laneLo ();
  sdc_lane_if laneHi ();

  // decode of the synchronised pin sample
  always_comb begin
    if (st.csN) begin
      cmd = SDC_NOP;                                      // R01
    end else if (!st.rasN && st.casN) begin               // R03
      if (st.weN) begin
        cmd = SDC_ACT;                                    // R04
      end else if (st.ad[ROW_PREC_ALL_BIT]) begin
        cmd = SDC_PREALL;                                 // R10
      end else begin
        cmd = SDC_PRE;                                    // R05
      end
    end else if (st.rasN && !st.casN) begin               // R06
      cmd = st.weN ? SDC_RD : SDC_WR;
    end else if (st.rasN && st.casN) begin
      cmd = SDC_NOP;
    end else begin
      cmd = SDC_OTHER;
    end
  end

  always_comb begin
    next_st = st;
    // two-stage capture of all pins on the rising edge
    next_st.csN1  = chipSelN;                             // R02
    next_st.rasN1 = rowStrobeN;
    next_st.casN1 = colStrobeN;
    next_st.weN1  = writeEnN;
    next_st.ba1   = bankSel;
    next_st.ad1   = addr;
    next_st.dqm1  = {upper_byte_mask, lower_byte_mask};
    next_st.dq1   = data_lines_in;                        // R08
    next_st.csN   = st.csN1;
    next_st.rasN  = st.rasN1;
    next_st.casN  = st.casN1;
    next_st.weN   = st.weN1;
    next_st.ba    = st.ba1;
    next_st.ad    = st.ad1;
    next_st.dqm   = st.dqm1;
    next_st.dq    = st.dq1;
    next_st.rd    = 1'b0;
    next_st.wr    = 1'b0;
    next_st.act   = 1'b0;
    next_st.pall  = 1'b0;
    next_st.dout  = readData;                             // R08
    case (cmd)
      SDC_ACT: begin
        if (!st.active[st.ba]) begin                      // R09
          next_st.active[st.ba] = 1'b1;                   // R04
          next_st.row = st.ad;                            // R09
          next_st.act = 1'b1;
        end
      end
      SDC_PRE: begin
        next_st.active[st.ba] = 1'b0;                     // R05
      end
      SDC_PREALL: begin
        next_st.active = BANKS_RESET;                     // R10
        next_st.pall   = 1'b1;
      end
      SDC_RD, SDC_WR: begin
        if (st.active[st.ba]) begin
          next_st.aBank = st.ba;                          // R06
          next_st.aCol  = st.ad[COL_W-1:0];
          next_st.rd    = (cmd == SDC_RD);
          next_st.wr    = (cmd == SDC_WR);
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // lane wiring: write data and write mask of the access cycle, and the read mask of the pin cycle after a read, go to each lane cell
  assign laneLo.wrData  = st.dq[LANE_LO_MSB:0];
  assign laneHi.wrData  = st.dq[DATA_W-1:LANE_HI_LSB];
  assign laneLo.mask    = st.dqm[0];                      // R07
  assign laneHi.mask    = st.dqm[1];                      // R07
  assign laneLo.rdPhase = st.rd;
  assign laneHi.rdPhase = st.rd;
  assign laneLo.wrPhase = (cmd == SDC_WR) && st.active[st.ba];
  assign laneHi.wrPhase = (cmd == SDC_WR) && st.active[st.ba];
  assign laneLo.rdData  = st.dout[LANE_LO_MSB:0];
  assign laneHi.rdData  = st.dout[DATA_W-1:LANE_HI_LSB];

  sdc_lane uLaneLo (.clk(clk), .nrst(nrst), .lif(laneLo));
  sdc_lane uLaneHi (.clk(clk), .nrst(nrst), .lif(laneHi));

  assign data_lines_out = st.dout;
  assign data_lines_oe  = {{8{laneHi.laneOe}}, {8{laneLo.laneOe}}}; // R07
  assign writeData      = {laneHi.laneStore, laneLo.laneStore};
  assign writeLaneEn    = {laneHi.laneWe, laneLo.laneWe};
  assign bankActive     = st.active;
  assign openRow        = st.row;
  assign accessBank     = st.aBank;
  assign accessCol      = st.aCol;
  assign readStrobe     = st.rd;
  assign writeStrobe    = st.wr;
  assign row_open_command       = st.act;
  assign all_bank_close_command = st.pall;

  a_cs_masks_cmd: assert property (@(posedge clk) disable iff (!nrst)
    st.csN |=> !readStrobe && !writeStrobe && !row_open_command
      && !all_bank_close_command && $stable(bankActive)) // R01
    else $error("command acted on while deselected");
  a_pin_to_act: assert property (@(posedge clk) disable iff (!nrst)
    !chipSelN && !rowStrobeN && colStrobeN && writeEnN && nrst
    ##1 nrst ##1 nrst |=> bankActive != BANKS_RESET) // R02
    else $error("activate pins did not open a bank in three edges");
  a_act_opens_bank: assert property (@(posedge clk) disable iff (!nrst)
    cmd == SDC_ACT |=> bankActive[$past(st.ba)]) // R04
    else $error("activate left bank idle");
  a_pre_closes_bank: assert property (@(posedge clk) disable iff (!nrst)
    cmd == SDC_PRE |=> !bankActive[$past(st.ba)]) // R05
    else $error("precharge left bank active");
  a_act_only_idle: assert property (@(posedge clk) disable iff (!nrst)
    cmd == SDC_ACT && st.active[st.ba] |=> $stable(openRow)
      && !row_open_command) // R09
    else $error("activate to active bank changed row");
  a_act_latch_row: assert property (@(posedge clk) disable iff (!nrst)
    row_open_command |-> openRow == $past(st.ad)) // R09
    else $error("row address not latched on activate");
  a_prechg_all: assert property (@(posedge clk) disable iff (!nrst)
    cmd == SDC_PREALL |=> bankActive == BANKS_RESET
      && all_bank_close_command) // R10
    else $error("precharge all left a bank active");
  a_rw_choice: assert property (@(posedge clk) disable iff (!nrst)
    (cmd == SDC_RD || cmd == SDC_WR) && st.active[st.ba]
      |=> readStrobe == $past(st.weN) && writeStrobe == !$past(st.weN)) // R06
    else $error("write enable did not pick read or write");
  a_ras_cas_sel: assert property (@(posedge clk) disable iff (!nrst)
    !st.csN && !st.rasN && st.casN |-> cmd inside {SDC_ACT, SDC_PRE,
      SDC_PREALL}) // R03
    else $error("row strobe command decoded wrongly");
  a_read_drive: assert property (@(posedge clk) disable iff (!nrst)
    readStrobe |=> data_lines_oe == {{8{!$past(st.dqm[1])}},
      {8{!$past(st.dqm[0])}}}) // R08
    else $error("read drive not masked per lane");

  c_activate: cover property (@(posedge clk) row_open_command);
  c_read:     cover property (@(posedge clk) readStrobe);
  c_write:    cover property (@(posedge clk) writeStrobe && writeLaneEn != 2'h0);
  c_prechall: cover property (@(posedge clk) all_bank_close_command);
endmodule

// ===== core/sdc_pkg.sv
// package: command encodings, bank states and widths for the command decoder
package sdc_pkg;
  localparam int DATA_W    = 16;
  localparam int ROW_W     = 12;
  localparam int COL_W     = 9;
  localparam int BANK_N    = 4;
  localparam int BANK_W    = 2;
  localparam int ROW_PREC_ALL_BIT = 10;
  localparam int LANE_LO_MSB = 7;
  localparam int LANE_HI_LSB = 8;
  localparam logic [BANK_N-1:0] BANKS_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;

  typedef enum logic [2:0] {
    SDC_NOP, SDC_ACT, SDC_PRE, SDC_PREALL, SDC_RD, SDC_WR, SDC_OTHER
  } sdc_cmd_t;
endpackage

// ===== core/sdc_lane_if.sv
// interface: per-lane data and mask signals between decoder and lane cells
`timescale 1ns/10ps
interface sdc_lane_if;
  logic [7:0] wrData;
  logic       mask;
  logic       rdPhase;
  logic       wrPhase;
  logic [7:0] rdData;
  logic       laneOe;
  logic       laneWe;
  logic [7:0] laneStore;
  modport ctrl (output rdData, mask, rdPhase, wrPhase, wrData,
                input laneOe, laneWe, laneStore);
  modport lane (input rdData, mask, rdPhase, wrPhase, wrData,
                output laneOe, laneWe, laneStore);
endinterface

// ===== core/sdc_lane.sv
// module: one byte lane, applies its mask to read drive and write store
`timescale 1ns/10ps
module sdc_lane
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  sdc_lane_if.lane lif
);
  typedef struct packed {
    logic       oe;
    logic       we;
    logic [7:0] store;
  } sdc_lane_st_t;

  sdc_lane_st_t st;
  sdc_lane_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.oe = lif.rdPhase & ~lif.mask;   // R07
    next_st.we = lif.wrPhase & ~lif.mask;   // R07
    if (lif.wrPhase && !lif.mask) begin
      next_st.store = lif.wrData;           // R08
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lif.laneOe    = st.oe;
  assign lif.laneWe    = st.we;
  assign lif.laneStore = st.store;

  a_mask_blocks_store: assert property (@(posedge clk) disable iff (!nrst)
    lif.wrPhase && lif.mask |=> !lif.laneWe && $stable(lif.laneStore)) // R07
    else $error("masked write lane stored data");
  a_mask_blocks_drive: assert property (@(posedge clk) disable iff (!nrst)
    lif.rdPhase |=> lif.laneOe == !$past(lif.mask)) // R07
    else $error("read lane drive does not follow mask");
endmodule

// ===== bench/sdc_ctrl_model.sv
// partner: memory controller model driving command, mask and data pins
`timescale 1ns/10ps
module sdc_ctrl_model
  import sdc_pkg::*;
(
  input  wire logic              clk,
  output logic      [3:0]        cmdPins,
  output logic      [BANK_W-1:0] bankSel,
  output logic      [ROW_W-1:0]  addr,
  output logic      [1:0]        byteMask,
  output logic      [DATA_W-1:0] dataOut
);
  // pins are {chip select, row strobe, column strobe, write enable}
  initial begin
    cmdPins = 4'hF;
    bankSel = 2'h0;
    addr = 12'h000;
    byteMask = 2'h0;
    dataOut = 16'h0000;
  end
  task automatic send(input logic [3:0] p, input logic [1:0] b,
                      input logic [11:0] a, input logic [1:0] m,
                      input logic [15:0] d);
    @(posedge clk);
    cmdPins <= p;
    bankSel <= b;
    addr <= a;
    byteMask <= m;
    dataOut <= d;
  endtask
  // idle cycles carry a no-operation; released data lines keep toggling
  task automatic idle();
    @(posedge clk);
    cmdPins <= 4'h7;
    dataOut <= ~dataOut;
  endtask
endmodule

// ===== bench/sdram_command_pin_decode_tb.sv
// testbench: command decoder against a queue-based reference model
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module sdram_command_pin_decode_tb;
  import sdc_pkg::*;
  typedef struct packed {
    logic [3:0] bank; logic rowOpen; logic allClose; logic rd; logic wr;
    logic [1:0] msk; logic [15:0] wdata; logic [11:0] row;
    logic [1:0] ab; logic [8:0] col;
  } sdc_exp_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [DATA_W-1:0] readData = 16'h0000;
  logic [3:0] cmdPins, act, p;
  logic [1:0] bankSel, byteMask, writeLaneEn, accessBank;
  logic [11:0] addr, openRow;
  logic [15:0] dataOut, data_lines_out, data_lines_oe, writeData, oeExp, lm;
  logic [8:0] accessCol;
  logic readStrobe, writeStrobe, row_open_command, all_bank_close_command;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  bit oeChk = 0;
  sdc_exp_t e, x, q[$];
  logic [3:0] act_unused_fix;
  logic [15:0] rdExp;
  bit rdChk = 0;
  sdc_ctrl_model i_sdc_ctrl_model (.clk(clk), .cmdPins(cmdPins),
    .bankSel(bankSel), .addr(addr), .byteMask(byteMask), .dataOut(dataOut));
  sdc_decoder i_sdc_decoder (.clk(clk), .nrst(nrst), .chipSelN(cmdPins[3]),
    .rowStrobeN(cmdPins[2]), .colStrobeN(cmdPins[1]),
    .writeEnN(cmdPins[0]), .bankSel(bankSel), .addr(addr),
    .lower_byte_mask(byteMask[0]), .upper_byte_mask(byteMask[1]),
    .data_lines_in(dataOut), .readData(readData),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .writeData(writeData), .writeLaneEn(writeLaneEn),
    .bankActive(act_unused_fix), .openRow(openRow),
    .accessBank(accessBank), .accessCol(accessCol),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe),
    .row_open_command(row_open_command),
    .all_bank_close_command(all_bank_close_command));
  always #25 clk = ~clk;
  always @(posedge clk) readData <= 16'($urandom);
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // reference: pins seen at edge E show up on the outputs at edge E+2
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      close_out();
    end
    e = '0;
    p = cmdPins;
    e.msk = byteMask;
    // read data is registered once, so it trails the array port by a cycle
    rdChk = nrst;
    rdExp = readData;
    if (!nrst) begin
      act = 4'h0;
      q.delete();
    end else begin
      if (!p[3]) begin
        case (p[2:0])
          3'b011: if (!act[bankSel]) begin
            act[bankSel] = 1'b1;
            e.rowOpen = 1'b1;
            e.row = addr;
          end
          3'b010: if (addr[10]) begin
            act = 4'h0;
            e.allClose = 1'b1;
          end else act[bankSel] = 1'b0;
          3'b101, 3'b100: if (act[bankSel]) begin
            e.rd = p[0];
            e.wr = !p[0];
            e.ab = bankSel;
            e.col = addr[8:0];
            e.wdata = dataOut;
          end
          default: ;
        endcase
      end
      e.bank = act;
      q.push_back(e);
    end
    #1;
    if (oeChk) `CHK(data_lines_oe, oeExp)
    else `CHK(data_lines_oe, 16'h0000)
    oeChk = 0;
    if (rdChk) `CHK(data_lines_out, rdExp)
    if (q.size() == 3) begin
      x = q.pop_front();
      lm = {{8{~x.msk[1]}}, {8{~x.msk[0]}}};
      `CHK(act_unused_fix, x.bank)
      `CHK(row_open_command, x.rowOpen)
      `CHK(all_bank_close_command, x.allClose)
      `CHK(readStrobe, x.rd)
      `CHK(writeStrobe, x.wr)
      `CHK(writeLaneEn, x.wr ? ~x.msk : 2'h0)
      if (x.rowOpen) `CHK(openRow, x.row)
      if (x.rd | x.wr) `CHK({accessBank, accessCol}, {x.ab, x.col})
      if (x.wr) `CHK(writeData & lm, x.wdata & lm)
      oeChk = x.rd;
      // read drivers follow the mask of the pin cycle after the read
      oeExp = {{8{~q[0].msk[1]}}, {8{~q[0].msk[0]}}};
    end
  end
  initial begin
    void'($urandom(32'hC2CB));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    i_sdc_ctrl_model.send(4'h3, 2'h1, 12'h5A3, 2'h0, 16'h0000);
    i_sdc_ctrl_model.send(4'h3, 2'h1, 12'h0FF, 2'h0, 16'h0000);
    i_sdc_ctrl_model.send(4'h4, 2'h1, 12'h1FF, 2'h1, 16'hBEEF);
    i_sdc_ctrl_model.send(4'h5, 2'h1, 12'h100, 2'h2, 16'h1234);
    i_sdc_ctrl_model.send(4'h5, 2'h2, 12'h0AA, 2'h0, 16'h0000);
    i_sdc_ctrl_model.send(4'hC, 2'h1, 12'h003, 2'h0, 16'hFFFF);
    i_sdc_ctrl_model.send(4'h2, 2'h3, 12'h400, 2'h0, 16'h0000);
    repeat (6) i_sdc_ctrl_model.idle();
    $display("test directed done");
    repeat (600)
      i_sdc_ctrl_model.send({$urandom_range(3, 0) == 0, 3'($urandom)},
        2'($urandom), 12'($urandom), 2'($urandom), 16'($urandom));
    repeat (6) i_sdc_ctrl_model.idle();
    $display("test random done");
    close_out();
  end
endmodule
